// *** dv/fieldbus_master.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Fieldbus master issuing APB transfers
// ----------------------------------------
module fieldbus_master (
   // Clock
   input wire logic pclk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [drive_stop_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   import drive_stop_pkg::*;
   // Bus idle at time zero
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer; request held until pready is seen high, for at most 50 access cycles
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      r = 'x;
      e = 'x;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            r = prdata;
            e = pslverr;
            break;
         end
      end
      // Released address and data show the inverse, never a stale value
      psel <= 0;
      penable <= 0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import drive_stop_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, rpm_value, ramp_speed_step;
   logic [15:0] ramp_time_step;
   ramp_kind_type ramp_kind;
   logic velocity_mode, quickstop_enter, shutdown_enter, standstill, resume_cmd, stop_now;
   logic brake_active, hold_energized, drive_blocked, to_switch_on_disabled, rpm_valid;
   int n_errors, n_compared, i;
   typedef struct {logic w; logic [ADDR_W-1:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_type;
   // Bus rows: write, address, data, read value, error
   row_type rows [13] = '{
      '{0, ADDR_QS_SPEED, 0, 32'h1388, 0}, '{0, ADDR_QS_TIME, 0, 1, 0},
      '{0, ADDR_UNIT_NUM, 0, 1, 0}, '{0, ADDR_UNIT_DEN, 0, 1, 0},
      '{0, ADDR_QS_ACTION, 0, 2, 0}, '{0, ADDR_SD_ACTION, 0, 1, 0},
      '{0, ADDR_SLOW_SPEED, 0, 32'h1F4, 0}, '{1, ADDR_QS_ACTION, 3, 0, 1},
      '{0, ADDR_QS_ACTION, 0, 2, 0}, '{1, ADDR_SD_ACTION, 2, 0, 1},
      '{1, ADDR_UNIT_DEN, 0, 0, 1}, '{1, 20'h00FF0, 0, 0, 1},
      '{1, ADDR_UNIT_NUM, 32'hFFFFFFFA, 0, 0}};
   drive_stop_action_select drive_stop_action_select_i (.*);
   fieldbus_master fieldbus_master_i (.*);
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task results;
      if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      fieldbus_master_i.xfer(w, a, d, rd, er);
      if (er === 1'bx) begin
         n_errors++;
         results;
      end
   endtask
   // Stop event pulse; returns where the answer has settled
   task ev(input logic q);
      @(posedge pclk);
      quickstop_enter <= q;
      shutdown_enter <= !q;
      @(posedge pclk);
      quickstop_enter <= 0;
      shutdown_enter <= 0;
      @(negedge pclk);
   endtask
   // Standstill (k=0) or resume command (k=1)
   task pin(input int k);
      @(posedge pclk);
      standstill <= k == 0;
      resume_cmd <= k == 1;
      @(posedge pclk);
      standstill <= 0;
      resume_cmd <= 0;
      @(negedge pclk);
   endtask
   initial begin
      #500000 n_errors++;
      results;
   end
   initial begin
      {presetn, velocity_mode, quickstop_enter, shutdown_enter, standstill, resume_cmd} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      foreach (rows[k]) begin
         bus(rows[k].w, rows[k].a, rows[k].d);
         chk(er, rows[k].e);
         if (!rows[k].w) chk(rd, rows[k].r);
      end
      velocity_mode <= 1;
      ev(1);
      chk(ramp_kind, RAMP_QUICK);
      chk(brake_active, 1);
      @(negedge pclk) chk(ramp_speed_step, RST_QS_SPEED);
      chk(ramp_time_step, RST_QS_TIME);
      pin(0);
      chk(to_switch_on_disabled, 1);
      bus(1, ADDR_QS_ACTION, 0);
      ev(1);
      chk(stop_now, 1);
      @(negedge pclk) chk(to_switch_on_disabled, 1);
      bus(1, ADDR_QS_ACTION, 6);
      ev(1);
      pin(0);
      chk(hold_energized, 1);
      pin(1);
      chk(hold_energized, 0);
      ev(0);
      chk(ramp_kind, RAMP_SLOW);
      @(negedge pclk) chk(ramp_speed_step, RST_SLOW_SPEED);
      pin(0);
      chk(to_switch_on_disabled, 1);
      bus(1, ADDR_SD_ACTION, 0);
      ev(0);
      chk(drive_blocked, 1);
      pin(1);
      velocity_mode <= 0;
      bus(1, ADDR_QS_ACTION, 1);
      ev(1);
      chk(ramp_kind, RAMP_SLOW);
      @(negedge pclk) chk(ramp_speed_step, 0);
      pin(0);
      chk(to_switch_on_disabled, 1);
      bus(1, ADDR_QS_ACTION, 5);
      ev(1);
      chk(ramp_kind, RAMP_SLOW);
      pin(0);
      chk(hold_energized, 1);
      pin(1);
      chk(hold_energized, 0);
      bus(1, ADDR_UNIT_DEN, 3);
      bus(1, ADDR_SPEED_IN, 10);
      for (i = 0; i < 200 && rpm_valid !== 1'b1; i++) @(negedge pclk);
      if (i == 200) begin
         n_errors++;
         results;
      end
      chk(rpm_value, 32'hFFFFFFEC);
      @(posedge pclk) presetn <= 0;
      @(posedge pclk) presetn <= 1;
      bus(0, ADDR_QS_ACTION, 0);
      chk(rd, RST_QS_ACTION);
      results;
   end
endmodule

// *** src/drive_stop_action_select.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// - Velocity quick stop uses dedicated ramp
// - Ramp is speed change over time change
// - Speed 32 bit 0x1388, time 16 bit 1
// - Velocity unit from signed numerator/denominator
// - Rpm equals speed times num over den
// - Quick stop entry runs selected code
// - Code 0: immediate stop, switch on disabled
// - Codes 1/2: slow/quick ramp, then disabled
// - Codes 5/6: brake, stay energized in quickstop
// - After 5/6, resume returns to operation
// - Shutdown transition runs shutdown code, default 1
// - Shutdown code 0: drive blocked, motor free
// - Shutdown code 1: slow ramp, then disabled
// - Slow ramp is velocity deceleration pair
module drive_stop_action_select (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [drive_stop_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Power state machine events
   input wire logic velocity_mode,
   input wire logic quickstop_enter,
   input wire logic shutdown_enter,
   input wire logic standstill,
   input wire logic resume_cmd,
   // Braking control
   output logic stop_now,
   output logic brake_active,
   output logic hold_energized,
   output logic drive_blocked,
   output logic to_switch_on_disabled,
   output drive_stop_pkg::ramp_kind_type ramp_kind,
   output logic [31:0] ramp_speed_step,
   output logic [15:0] ramp_time_step,
   // Speed conversion
   output logic [31:0] rpm_value,
   output logic rpm_valid
);
   import drive_stop_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [31:0] qs_speed_step, next_qs_speed_step; // Quick-stop speed change
   logic [15:0] qs_time_step, next_qs_time_step; // Quick-stop time change
   logic [31:0] unit_num, next_unit_num; // Unit numerator
   logic [31:0] unit_den, next_unit_den; // Unit denominator
   logic [15:0] qs_action, next_qs_action; // Quick-stop action code
   logic [15:0] sd_action, next_sd_action; // Shutdown action code
   logic [31:0] slow_speed_step, next_slow_speed_step; // Slow-down speed change
   logic [15:0] slow_time_step, next_slow_time_step; // Slow-down time change
   logic [31:0] speed_in, next_speed_in; // Speed to convert
   logic next_pready; // Next ready
   logic [31:0] next_prdata; // Next read data
   logic next_pslverr; // Next error
   logic setup; // Setup phase of a transfer
   logic wr_ok; // Accepted write at this edge
   logic conv_start; // Start a conversion
   logic conv_busy; // Conversion running
   stop_state_type state, next_state; // Stop sequencer
   logic hold_after, next_hold_after; // Stay in quick stop after braking
   ramp_kind_type next_ramp_kind; // Next ramp kind
   logic next_stop_now; // Next immediate stop
   logic next_brake_active; // Next braking
   logic next_hold_energized; // Next hold
   logic next_drive_blocked; // Next drive blocked
   logic next_to_sod; // Next switch-on-disabled pulse

   // Known quick-stop codes
   function automatic logic qs_code_ok(input logic [15:0] code);
      return code == QS_IMMEDIATE || code == QS_SLOW || code == QS_QUICK
         || code == QS_SLOW_HOLD || code == QS_QUICK_HOLD;
   endfunction

   // Known shutdown codes
   function automatic logic sd_code_ok(input logic [15:0] code);
      return code == SD_FREE || code == SD_SLOW;
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   assign setup = psel && !penable;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;

   // Decode in setup, answer in the first access cycle, write at its end
   always_comb begin
      next_qs_speed_step = qs_speed_step;
      next_qs_time_step = qs_time_step;
      next_unit_num = unit_num;
      next_unit_den = unit_den;
      next_qs_action = qs_action;
      next_sd_action = sd_action;
      next_slow_speed_step = slow_speed_step;
      next_slow_time_step = slow_time_step;
      next_speed_in = speed_in;
      next_pready = setup;
      next_prdata = prdata;
      next_pslverr = pslverr;
      conv_start = 1'b0;
      if (setup) begin
         next_prdata = 32'h00000000;
         next_pslverr = 1'b0;
         case (paddr)
            ADDR_QS_SPEED: next_prdata = qs_speed_step;
            ADDR_QS_TIME: next_prdata = {16'h0000, qs_time_step};
            ADDR_UNIT_NUM: next_prdata = unit_num;
            ADDR_UNIT_DEN: begin
               next_prdata = unit_den;
               if (pwrite && pwdata == 32'h00000000) begin
                  next_pslverr = 1'b1;
               end
            end
            ADDR_QS_ACTION: begin
               next_prdata = {16'h0000, qs_action};
               if (pwrite && !qs_code_ok(pwdata[15:0])) begin
                  next_pslverr = 1'b1;
               end
            end
            ADDR_SD_ACTION: begin
               next_prdata = {16'h0000, sd_action};
               if (pwrite && !sd_code_ok(pwdata[15:0])) begin
                  next_pslverr = 1'b1;
               end
            end
            ADDR_SLOW_SPEED: next_prdata = slow_speed_step;
            ADDR_SLOW_TIME: next_prdata = {16'h0000, slow_time_step};
            ADDR_SPEED_IN: begin
               next_prdata = speed_in;
               next_pslverr = pwrite && conv_busy;
            end
            ADDR_RPM: begin
               next_prdata = rpm_value;
               next_pslverr = pwrite;
            end
            ADDR_STATUS: begin
               next_prdata[STAT_STATE_LSB +: 3] = 3'(state);
               next_prdata[STAT_BUSY_BIT] = conv_busy;
               next_pslverr = pwrite;
            end
            default: next_pslverr = 1'b1;
         endcase
      end
      if (wr_ok) begin
         case (paddr)
            ADDR_QS_SPEED: next_qs_speed_step = pwdata;
            ADDR_QS_TIME: next_qs_time_step = pwdata[15:0];
            ADDR_UNIT_NUM: next_unit_num = pwdata;
            ADDR_UNIT_DEN: next_unit_den = pwdata;
            ADDR_QS_ACTION: next_qs_action = pwdata[15:0];
            ADDR_SD_ACTION: next_sd_action = pwdata[15:0];
            ADDR_SLOW_SPEED: next_slow_speed_step = pwdata;
            ADDR_SLOW_TIME: next_slow_time_step = pwdata[15:0];
            ADDR_SPEED_IN: begin
               next_speed_in = pwdata;
               conv_start = 1'b1;
            end
            default: next_speed_in = speed_in;
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qs_speed_step <= RST_QS_SPEED;
         qs_time_step <= RST_QS_TIME;
         unit_num <= RST_UNIT_NUM;
         unit_den <= RST_UNIT_DEN;
         qs_action <= RST_QS_ACTION;
         sd_action <= RST_SD_ACTION;
         slow_speed_step <= RST_SLOW_SPEED;
         slow_time_step <= RST_SLOW_TIME;
         speed_in <= 32'h00000000;
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         qs_speed_step <= next_qs_speed_step;
         qs_time_step <= next_qs_time_step;
         unit_num <= next_unit_num;
         unit_den <= next_unit_den;
         qs_action <= next_qs_action;
         sd_action <= next_sd_action;
         slow_speed_step <= next_slow_speed_step;
         slow_time_step <= next_slow_time_step;
         speed_in <= next_speed_in;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // Stop sequencer
   // ----------------------------------------
   // Quick stop wins over shutdown when both arrive together
   always_comb begin
      next_state = state;
      next_hold_after = hold_after;
      next_ramp_kind = ramp_kind;
      next_to_sod = 1'b0;
      case (state)
         ST_IDLE: begin
            if (quickstop_enter) begin
               case (qs_action)
                  QS_IMMEDIATE: begin
                     next_state = ST_STOP_NOW;
                     next_ramp_kind = RAMP_NONE;
                  end
                  QS_SLOW, QS_SLOW_HOLD: begin
                     next_state = ST_BRAKE;
                     next_ramp_kind = RAMP_SLOW;
                     next_hold_after = (qs_action == QS_SLOW_HOLD);
                  end
                  default: begin
                     next_state = ST_BRAKE;
                     next_ramp_kind = RAMP_QUICK;
                     next_hold_after = (qs_action == QS_QUICK_HOLD);
                  end
               endcase
            end else if (shutdown_enter) begin
               if (sd_action == SD_FREE) begin
                  next_state = ST_FREE;
                  next_ramp_kind = RAMP_NONE;
               end else begin
                  next_state = ST_BRAKE;
                  next_ramp_kind = RAMP_SLOW;
                  next_hold_after = 1'b0;
               end
            end
         end
         ST_STOP_NOW: begin
            next_state = ST_IDLE;
            next_to_sod = 1'b1;
         end
         ST_BRAKE: begin
            if (standstill) begin
               next_ramp_kind = RAMP_NONE;
               if (hold_after) begin
                  next_state = ST_HOLD;
               end else begin
                  next_state = ST_IDLE;
                  next_to_sod = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (resume_cmd) begin
               next_state = ST_IDLE;
               next_hold_after = 1'b0;
            end
         end
         ST_FREE: begin
            if (resume_cmd) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_stop_now = (next_state == ST_STOP_NOW);
      next_brake_active = (next_state == ST_BRAKE);
      next_hold_energized = (next_state == ST_HOLD);
      next_drive_blocked = (next_state == ST_FREE);
   end

   // Sequencer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         hold_after <= 1'b0;
         ramp_kind <= RAMP_NONE;
         stop_now <= 1'b0;
         brake_active <= 1'b0;
         hold_energized <= 1'b0;
         drive_blocked <= 1'b0;
         to_switch_on_disabled <= 1'b0;
      end else begin
         state <= next_state;
         hold_after <= next_hold_after;
         ramp_kind <= next_ramp_kind;
         stop_now <= next_stop_now;
         brake_active <= next_brake_active;
         hold_energized <= next_hold_energized;
         drive_blocked <= next_drive_blocked;
         to_switch_on_disabled <= next_to_sod;
      end
   end

   // ----------------------------------------
   // Ramp and speed conversion
   // ----------------------------------------
   ramp_pick #(.SPEED_W(32), .TIME_W(16)) u_ramp (
      .pclk(pclk),
      .presetn(presetn),
      .velocity_mode(velocity_mode),
      .kind(ramp_kind),
      .quick_speed(qs_speed_step),
      .quick_time(qs_time_step),
      .slow_speed(slow_speed_step),
      .slow_time(slow_time_step),
      .speed_step(ramp_speed_step),
      .time_step(ramp_time_step)
   );

   speed_to_rpm #(.W(32)) u_rpm (
      .pclk(pclk),
      .presetn(presetn),
      .start(conv_start),
      // The start edge also stores the word, so hand over the word itself
      .speed(next_speed_in),
      .num(unit_num),
      .den(unit_den),
      .busy(conv_busy),
      .rpm(rpm_value),
      .done(rpm_valid)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_qs_quick;
      (state == ST_IDLE && quickstop_enter && qs_action == QS_QUICK)
         |=> (brake_active && ramp_kind == RAMP_QUICK);
   endproperty
   a_qs_quick: assert property (p_qs_quick) else $error("quick ramp not started");

   property p_qs_immediate;
      (state == ST_IDLE && quickstop_enter && qs_action == QS_IMMEDIATE)
         |=> stop_now ##1 (to_switch_on_disabled && !stop_now);
   endproperty
   a_qs_immediate: assert property (p_qs_immediate) else $error("immediate stop sequence wrong");

   property p_hold_after_brake;
      (state == ST_BRAKE && hold_after && standstill) |=> (hold_energized && !to_switch_on_disabled);
   endproperty
   a_hold_after_brake: assert property (p_hold_after_brake) else $error("hold not kept");

   property p_resume;
      (hold_energized && resume_cmd) |=> (!hold_energized && state == ST_IDLE);
   endproperty
   a_resume: assert property (p_resume) else $error("resume ignored");

   property p_sd_free;
      (state == ST_IDLE && !quickstop_enter && shutdown_enter && sd_action == SD_FREE)
         |=> (drive_blocked && !brake_active);
   endproperty
   a_sd_free: assert property (p_sd_free) else $error("drive not blocked");

   property p_sd_slow;
      (state == ST_IDLE && !quickstop_enter && shutdown_enter && sd_action == SD_SLOW)
         |=> (brake_active && ramp_kind == RAMP_SLOW);
   endproperty
   a_sd_slow: assert property (p_sd_slow) else $error("shutdown ramp not started");

   property p_code_reserved;
      (setup && pwrite && paddr == ADDR_QS_ACTION && !qs_code_ok(pwdata[15:0]))
         |=> (pready && pslverr) ##1 $stable(qs_action);
   endproperty
   a_code_reserved: assert property (p_code_reserved) else $error("reserved code stored");

   property p_den_zero;
      (setup && pwrite && paddr == ADDR_UNIT_DEN && pwdata == 32'h00000000)
         |=> ##1 (unit_den != 32'h00000000);
   endproperty
   a_den_zero: assert property (p_den_zero) else $error("zero denominator stored");

endmodule

// *** src/drive_stop_pkg.sv ***
// ----------------------------------------
// Shared constants for the stop-action block
// ----------------------------------------
package drive_stop_pkg;

   // Bus geometry
   localparam int ADDR_W = 20;

   // Object indices; a register's byte address is four times its index
   localparam logic [15:0] IDX_QS_RAMP = 16'h604A;
   localparam logic [15:0] IDX_UNIT_SCALE = 16'h604C;
   localparam logic [15:0] IDX_QS_ACTION = 16'h605A;
   localparam logic [15:0] IDX_SD_ACTION = 16'h605B;

   // Byte addresses of the indexed registers
   localparam logic [ADDR_W-1:0] ADDR_QS_SPEED = {2'b00, IDX_QS_RAMP, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_UNIT_NUM = {2'b00, IDX_UNIT_SCALE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_QS_ACTION = {2'b00, IDX_QS_ACTION, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SD_ACTION = {2'b00, IDX_SD_ACTION, 2'b00};

   // Byte addresses of the second sub-entries and local registers
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 20'h00004;
   localparam logic [ADDR_W-1:0] ADDR_QS_TIME = 20'h00008;
   localparam logic [ADDR_W-1:0] ADDR_UNIT_DEN = 20'h0000C;
   localparam logic [ADDR_W-1:0] ADDR_SLOW_SPEED = 20'h00010;
   localparam logic [ADDR_W-1:0] ADDR_SLOW_TIME = 20'h00014;
   localparam logic [ADDR_W-1:0] ADDR_SPEED_IN = 20'h00018;
   localparam logic [ADDR_W-1:0] ADDR_RPM = 20'h0001C;

   // Reset values
   localparam logic [31:0] RST_QS_SPEED = 32'h00001388;
   localparam logic [15:0] RST_QS_TIME = 16'h0001;
   localparam logic [31:0] RST_UNIT_NUM = 32'h00000001;
   localparam logic [31:0] RST_UNIT_DEN = 32'h00000001;
   localparam logic [15:0] RST_QS_ACTION = 16'h0002;
   localparam logic [15:0] RST_SD_ACTION = 16'h0001;
   localparam logic [31:0] RST_SLOW_SPEED = 32'h000001F4;
   localparam logic [15:0] RST_SLOW_TIME = 16'h0001;

   // Quick-stop action codes
   localparam logic [15:0] QS_IMMEDIATE = 16'h0000;
   localparam logic [15:0] QS_SLOW = 16'h0001;
   localparam logic [15:0] QS_QUICK = 16'h0002;
   localparam logic [15:0] QS_SLOW_HOLD = 16'h0005;
   localparam logic [15:0] QS_QUICK_HOLD = 16'h0006;

   // Shutdown action codes
   localparam logic [15:0] SD_FREE = 16'h0000;
   localparam logic [15:0] SD_SLOW = 16'h0001;

   // Status field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_BUSY_BIT = 4;

   // Stop sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_STOP_NOW, ST_BRAKE, ST_HOLD, ST_FREE} stop_state_type;

   // Braking ramp kinds
   typedef enum logic [1:0] {RAMP_NONE, RAMP_SLOW, RAMP_QUICK} ramp_kind_type;

endpackage

// *** src/ramp_pick.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Velocity-mode braking ramp selection
// ----------------------------------------
module ramp_pick #(
   parameter int SPEED_W = 32,
   parameter int TIME_W = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Selection
   input wire logic velocity_mode,
   input wire drive_stop_pkg::ramp_kind_type kind,
   // Ramp parameter sets
   input wire logic [SPEED_W-1:0] quick_speed,
   input wire logic [TIME_W-1:0] quick_time,
   input wire logic [SPEED_W-1:0] slow_speed,
   input wire logic [TIME_W-1:0] slow_time,
   // Chosen ramp
   output logic [SPEED_W-1:0] speed_step,
   output logic [TIME_W-1:0] time_step
);
   import drive_stop_pkg::*;

   initial begin
      if (SPEED_W < 1 || TIME_W < 1) $error("ramp_pick: widths must be positive");
   end

   logic [SPEED_W-1:0] next_speed_step; // Next speed change
   logic [TIME_W-1:0] next_time_step; // Next time change

   // Velocity mode takes its own ramp pair; other modes see zero here
   always_comb begin
      next_speed_step = '0;
      next_time_step = '0;
      if (velocity_mode && kind == RAMP_QUICK) begin
         next_speed_step = quick_speed;
         next_time_step = quick_time;
      end else if (velocity_mode && kind == RAMP_SLOW) begin
         next_speed_step = slow_speed;
         next_time_step = slow_time;
      end
   end

   // Register the chosen pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_step <= '0;
         time_step <= '0;
      end else begin
         speed_step <= next_speed_step;
         time_step <= next_time_step;
      end
   end

   property p_quick_ramp;
      @(posedge pclk) disable iff (!presetn)
      (velocity_mode && kind == RAMP_QUICK) |=> (speed_step == $past(quick_speed) && time_step == $past(quick_time));
   endproperty
   a_quick_ramp: assert property (p_quick_ramp) else $error("quick-stop ramp not applied");

   property p_slow_ramp;
      @(posedge pclk) disable iff (!presetn)
      (velocity_mode && kind == RAMP_SLOW) |=> (speed_step == $past(slow_speed));
   endproperty
   a_slow_ramp: assert property (p_slow_ramp) else $error("slow-down ramp not applied");

endmodule

// *** src/speed_to_rpm.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Speed scaling: speed * numerator / denominator
// ----------------------------------------
module speed_to_rpm #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request
   input wire logic start,
   input wire logic [W-1:0] speed,
   input wire logic [W-1:0] num,
   input wire logic [W-1:0] den,
   // Result
   output logic busy,
   output logic [W-1:0] rpm,
   output logic done
);
   initial begin
      if (W < 2 || W > 32) $error("speed_to_rpm: W out of range");
   end

   logic [W:0] rem, next_rem; // Partial remainder
   logic [2*W-1:0] quo, next_quo; // Dividend shifting into quotient
   logic [W-1:0] div, next_div; // Divisor magnitude
   logic neg, next_neg; // Result sign
   logic [6:0] cnt, next_cnt; // Steps left
   logic next_busy; // Next busy
   logic [W-1:0] next_rpm; // Next result
   logic next_done; // Next done pulse
   logic signed [2*W-1:0] prod; // Signed product
   logic [W:0] shifted; // Remainder after shift

   // Multiply once, then restoring division one bit per cycle
   always_comb begin
      prod = $signed(speed) * $signed(num);
      shifted = {rem[W-1:0], quo[2*W-1]};
      next_rem = rem;
      next_quo = quo;
      next_div = div;
      next_neg = neg;
      next_cnt = cnt;
      next_busy = busy;
      next_rpm = rpm;
      next_done = 1'b0;
      if (start && !busy) begin
         next_quo = prod[2*W-1] ? -prod : prod;
         next_div = den[W-1] ? -den : den;
         next_neg = prod[2*W-1] ^ den[W-1];
         next_rem = '0;
         next_cnt = 7'(2 * W);
         next_busy = 1'b1;
      end else if (busy) begin
         next_quo = {quo[2*W-2:0], 1'b0};
         next_rem = shifted;
         if (shifted >= {1'b0, div}) begin
            next_rem = shifted - {1'b0, div};
            next_quo[0] = 1'b1;
         end
         next_cnt = cnt - 7'd1;
         if (cnt == 7'd1) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_rpm = neg ? -next_quo[W-1:0] : next_quo[W-1:0];
         end
      end
   end

   // Register the divider state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem <= '0;
         quo <= '0;
         div <= '0;
         neg <= 1'b0;
         cnt <= 7'h00;
         busy <= 1'b0;
         rpm <= '0;
         done <= 1'b0;
      end else begin
         rem <= next_rem;
         quo <= next_quo;
         div <= next_div;
         neg <= next_neg;
         cnt <= next_cnt;
         busy <= next_busy;
         rpm <= next_rpm;
         done <= next_done;
      end
   end

   property p_div_length;
      @(posedge pclk) disable iff (!presetn)
      (start && !busy) |=> busy [*8];
   endproperty
   a_div_length: assert property (p_div_length) else $error("division ended early");

endmodule
